//--- rtl/amrg_consts.svh
`ifndef AMRG_CONSTS_SVH
`define AMRG_CONSTS_SVH
// clock rate in MHz, 40 ns period
`define AMRG_CLK_MHZ 25
// delay from mute request until switching stops, ns (longest, round down)
`define AMRG_MUTE_NS 10000
`define AMRG_MUTE_CYC ((`AMRG_MUTE_NS * `AMRG_CLK_MHZ) / 1000)
// delay from mute release until switching starts, ns (least, round up)
`define AMRG_UNMUTE_NS 34000
`define AMRG_UNMUTE_CYC ((`AMRG_UNMUTE_NS * `AMRG_CLK_MHZ + 999) / 1000)
// start-up initialisation length, ns
`define AMRG_INIT_NS 100000
`define AMRG_INIT_CYC ((`AMRG_INIT_NS * `AMRG_CLK_MHZ + 999) / 1000)
// recommended settle time after reset release, ms
`define AMRG_SETTLE_MS 1000
`define AMRG_SETTLE_CYC (`AMRG_SETTLE_MS * `AMRG_CLK_MHZ * 1000)
// cycles per soft-start ramp step
`define AMRG_SOFT_STEP_CYC 32
`define AMRG_SOFT_FULL 3'h7
`define AMRG_TMR_W 12
`define AMRG_SETTLE_W 25
`endif

//--- rtl/amrg_pkg.sv
package amrg_pkg;
    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_INIT   = 3'b001,
        ST_MUTED  = 3'b010,
        ST_UNWAIT = 3'b011,
        ST_SOFT   = 3'b100,
        ST_RUN    = 3'b101,
        ST_MUTING = 3'b110
    } amrg_state_e;

    typedef struct packed {
        logic       mod_run;
        logic       drive_en;
        logic       tristate;
        logic [2:0] soft_level;
    } amrg_stage_s;
endpackage

//--- rtl/amrg_ctrl.sv
// Notes on behaviour
// - reset held: modulator stopped, stage tristated
// - reset release runs start-up initialisation
// - after start-up: modulator runs, stage undriven
// - mute release after settling starts soft-start drive
// - muted: power transistors never switch
// - early unmute still plays, shorter start sequence
// - modulator clock is input clock halved
// - timing scales with the input clock
// - gain pins 00..11 give 1,2,4,8
// - gain pins sampled continuously, applied live
// - gain acts ahead of the modulator
// - reset and mute pins active low
// - switching stops 10 us plus the pin sync delay after mute
// - switching starts 34 us after unmute
`timescale 1ns/1ps
`include "amrg_consts.svh"

module amrg_ctrl #(
    parameter int SETTLE_CYC = `AMRG_SETTLE_CYC
) (
    input  wire logic                 clock_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 amp_reset_b_in,
    input  wire logic                 mute_b_in,
    input  wire logic                 gain_select_msb_in,
    input  wire logic                 gain_select_lsb_in,
    output amrg_pkg::amrg_stage_s     stage_out,
    output logic                      mod_clk_out,
    output logic [3:0]                gain_mult_out,
    output logic                      early_unmute_out,
    output amrg_pkg::amrg_state_e     state_out
);
    import amrg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic       rst_s1_ff;
    logic       rst_n_ff;
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic       pin_rst_n;
    logic       pin_mute_n;
    logic [1:0] gain_sel;

    // async assert, synchronous release of the system reset
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
        end else begin
            pin_s1_ff <= {amp_reset_b_in, mute_b_in, gain_select_msb_in, gain_select_lsb_in};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // low level means reset or mute request
    assign pin_rst_n  = pin_s2_ff[3];
    assign pin_mute_n = pin_s2_ff[2];
    assign gain_sel   = pin_s2_ff[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // gain select

    // one-hot multiplier for the front-end gain
    function automatic logic [3:0] gain_mult(input logic [1:0] sel);
        gain_mult = 4'h1 << sel;
    endfunction

    logic [3:0] gain_ff;
    logic [3:0] nxt_gain;

    // feeds front end ahead of modulator
    always_comb begin
        nxt_gain = gain_mult(gain_sel);
    end

    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            gain_ff <= 4'h1;
        end else begin
            gain_ff <= nxt_gain;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settle counter since reset release

    logic [`AMRG_SETTLE_W-1:0] settle_ff;
    logic [`AMRG_SETTLE_W-1:0] nxt_settle;
    logic                      settled;

    assign settled = (settle_ff == SETTLE_CYC[`AMRG_SETTLE_W-1:0]);

    always_comb begin
        nxt_settle = settle_ff;
        if (!pin_rst_n) begin
            nxt_settle = '0;
        end else if (!settled) begin
            nxt_settle = settle_ff + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            settle_ff <= '0;
        end else begin
            settle_ff <= nxt_settle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    amrg_state_e           state_ff;
    amrg_state_e           nxt_state;
    logic [`AMRG_TMR_W-1:0] tmr_ff;
    logic [`AMRG_TMR_W-1:0] nxt_tmr;
    logic [2:0]            lvl_ff;
    logic [2:0]            nxt_lvl;
    logic                  early_ff;
    logic                  nxt_early;
    logic                  tmr_done;

    assign tmr_done = (tmr_ff == '0);

    // next state, delay timer and soft ramp level
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr   = tmr_done ? tmr_ff : tmr_ff - 1'b1;
        nxt_lvl   = lvl_ff;
        nxt_early = early_ff;
        case (state_ff)
            ST_RESET: begin
                nxt_state = ST_INIT;
                nxt_tmr   = `AMRG_TMR_W'(`AMRG_INIT_CYC - 1);
            end
            ST_INIT: begin
                if (tmr_done) begin
                    nxt_state = ST_MUTED;
                end
            end
            ST_MUTED: begin
                nxt_lvl = 3'h0;
                // mute release begins start of drive
                if (pin_mute_n) begin
                    nxt_state = ST_UNWAIT;
                    nxt_tmr   = `AMRG_TMR_W'(`AMRG_UNMUTE_CYC - 1);
                    nxt_early = !settled;
                end
            end
            ST_UNWAIT: begin
                // hold off switching for the unmute delay
                if (!pin_mute_n) begin
                    nxt_state = ST_MUTED;
                end else if (tmr_done && early_ff) begin
                    // short sequence: straight to full drive
                    nxt_state = ST_RUN;
                    nxt_lvl   = `AMRG_SOFT_FULL;
                end else if (tmr_done) begin
                    nxt_state = ST_SOFT;
                    nxt_tmr   = `AMRG_TMR_W'(`AMRG_SOFT_STEP_CYC - 1);
                end
            end
            ST_SOFT: begin
                if (!pin_mute_n) begin
                    nxt_state = ST_MUTING;
                    nxt_tmr   = `AMRG_TMR_W'(`AMRG_MUTE_CYC - 1);
                end else if (tmr_done && lvl_ff == `AMRG_SOFT_FULL) begin
                    nxt_state = ST_RUN;
                end else if (tmr_done) begin
                    nxt_lvl = lvl_ff + 3'h1;
                    nxt_tmr = `AMRG_TMR_W'(`AMRG_SOFT_STEP_CYC - 1);
                end
            end
            ST_RUN: begin
                if (!pin_mute_n) begin
                    nxt_state = ST_MUTING;
                    nxt_tmr   = `AMRG_TMR_W'(`AMRG_MUTE_CYC - 1);
                end
            end
            ST_MUTING: begin
                // stop switching once the mute delay ends
                if (tmr_done) begin
                    nxt_state = ST_MUTED;
                    nxt_lvl   = 3'h0;
                end
            end
            default: begin
                nxt_state = ST_RESET;
            end
        endcase
        if (!pin_rst_n) begin
            nxt_state = ST_RESET;
            nxt_tmr   = '0;
            nxt_lvl   = 3'h0;
            nxt_early = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= ST_RESET;
            tmr_ff   <= '0;
            lvl_ff   <= 3'h0;
            early_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff   <= nxt_tmr;
            lvl_ff   <= nxt_lvl;
            early_ff <= nxt_early;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output stage control and modulator clock

    amrg_stage_s stage_ff;
    amrg_stage_s nxt_stage;
    logic        modclk_ff;
    logic        nxt_modclk;

    // outputs follow the next state so they line up with state_ff
    always_comb begin
        nxt_stage.mod_run    = (nxt_state != ST_RESET);
        // drive only while unmuted or finishing the mute delay
        nxt_stage.drive_en   = (nxt_state == ST_SOFT) || (nxt_state == ST_RUN) ||
                               (nxt_state == ST_MUTING);
        nxt_stage.tristate   = !nxt_stage.drive_en;
        nxt_stage.soft_level = nxt_stage.drive_en ? nxt_lvl : 3'h0;
        // halve the input clock, scaling with it
        nxt_modclk           = nxt_stage.mod_run ? !modclk_ff : 1'b0;
    end

    always_ff @(posedge clock_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            stage_ff  <= '{mod_run: 1'b0, drive_en: 1'b0, tristate: 1'b1, soft_level: 3'h0};
            modclk_ff <= 1'b0;
        end else begin
            stage_ff  <= nxt_stage;
            modclk_ff <= nxt_modclk;
        end
    end

    assign stage_out        = stage_ff;
    assign mod_clk_out      = modclk_ff;
    assign gain_mult_out    = gain_ff;
    assign early_unmute_out = early_ff;
    assign state_out        = state_ff;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_ff);

    reset_quiet_a: assert property (
        state_ff == ST_RESET |-> stage_ff.tristate && !stage_ff.mod_run && !modclk_ff)
        else $error("stage not quiet in reset");

    reset_abort_a: assert property (
        !pin_rst_n |=> state_ff == ST_RESET && stage_ff.tristate)
        else $error("reset did not abort sequence");

    startup_entry_a: assert property (
        state_ff == ST_RESET && pin_rst_n |=> state_ff == ST_INIT &&
            tmr_ff == `AMRG_TMR_W'(`AMRG_INIT_CYC - 1))
        else $error("start-up not entered");

    muted_running_a: assert property (
        state_ff == ST_MUTED |-> stage_ff.mod_run && stage_ff.tristate)
        else $error("muted state wrong");

    muted_no_drive_a: assert property (
        state_ff == ST_MUTED || state_ff == ST_UNWAIT |-> !stage_ff.drive_en)
        else $error("switching while muted");

    mute_stop_a: assert property (
        $fell(pin_mute_n) && pin_rst_n && stage_ff.drive_en |-> ##[1:252] !stage_ff.drive_en)
        else $error("mute delay exceeded");

    unmute_load_a: assert property (
        $rose(state_ff == ST_UNWAIT) |-> tmr_ff == `AMRG_TMR_W'(`AMRG_UNMUTE_CYC - 1))
        else $error("unmute delay wrong");

    soft_start_a: assert property (
        state_ff == ST_UNWAIT && tmr_done && !early_ff && pin_mute_n && pin_rst_n
            |=> state_ff == ST_SOFT && stage_ff.drive_en && stage_ff.soft_level == 3'h0)
        else $error("soft start not begun");

    early_unmute_a: assert property (
        state_ff == ST_UNWAIT && tmr_done && early_ff && pin_mute_n && pin_rst_n
            |=> state_ff == ST_RUN && stage_ff.soft_level == `AMRG_SOFT_FULL)
        else $error("short sequence failed");

    modclk_half_a: assert property (
        stage_ff.mod_run && $past(stage_ff.mod_run) |-> modclk_ff != $past(modclk_ff))
        else $error("modulator clock not halved");

    gain_follow_a: assert property (
        ##1 gain_ff == (4'h1 << $past(gain_sel)))
        else $error("gain not applied");

    full_soft_c: cover property (state_ff == ST_SOFT ##[1:300] state_ff == ST_RUN);
    early_run_c: cover property (early_ff && state_ff == ST_RUN);
    mute_down_c: cover property (state_ff == ST_MUTING ##[1:300] state_ff == ST_MUTED);
    reset_abort_c: cover property (state_ff == ST_SOFT ##1 state_ff == ST_RESET);

endmodule

//--- testbench/amrg_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host controller model: drives reset, mute and gain pins at the falling edge
module amrg_host #(
    parameter int SETTLE_CYC = 3000
) (
    input  wire logic clock_in,
    output logic      amp_reset_b_out,
    output logic      mute_b_out,
    output logic      gain_select_msb_out,
    output logic      gain_select_lsb_out
);
    int since_rst_ff = 0;

    initial begin
        amp_reset_b_out     = 1'h0;
        mute_b_out          = 1'h0;
        gain_select_msb_out = 1'h0;
        gain_select_lsb_out = 1'h0;
    end

    // cycles since the reset pin went high
    always @(posedge clock_in) begin
        since_rst_ff <= amp_reset_b_out ? since_rst_ff + 1 : 0;
    end

    // pin changes, each at the next falling edge
    task automatic set_reset(input logic v);
        @(negedge clock_in);
        amp_reset_b_out = v;
    endtask

    task automatic set_mute(input logic v);
        @(negedge clock_in);
        mute_b_out = v;
    endtask

    task automatic set_gain(input logic [1:0] g);
        @(negedge clock_in);
        {gain_select_msb_out, gain_select_lsb_out} = g;
    endtask

    // unmute only after the settle time
    task automatic unmute_settled();
        while (since_rst_ff < SETTLE_CYC) @(negedge clock_in);
        set_mute(1'h1);
    endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`include "amrg_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the mute, reset and gain control
module tb_top;
    import amrg_pkg::*;
    localparam int SETTLE = 3000;
    localparam int INIT   = `AMRG_INIT_CYC;
    localparam int UNM    = `AMRG_UNMUTE_CYC;
    localparam int MUT    = `AMRG_MUTE_CYC;
    localparam int RAMP   = 8 * `AMRG_SOFT_STEP_CYC;

    logic        clock_in = 1'h0;
    logic        rst_b_in = 1'h0;
    logic        amp_reset_b;
    logic        mute_b;
    logic        gsel_msb;
    logic        gsel_lsb;
    amrg_stage_s stage;
    logic        mod_clk;
    logic [3:0]  gain_mult;
    logic        early;
    amrg_state_e state;
    int          n_errors = 0;
    int          n_checks = 0;

    // 25 MHz clock
    always #20 clock_in = ~clock_in;

    amrg_host #(.SETTLE_CYC(SETTLE)) i_amrg_host (
        .clock_in            (clock_in),
        .amp_reset_b_out     (amp_reset_b),
        .mute_b_out          (mute_b),
        .gain_select_msb_out (gsel_msb),
        .gain_select_lsb_out (gsel_lsb)
    );

    amrg_ctrl #(.SETTLE_CYC(SETTLE)) i_amrg_ctrl (
        .clock_in           (clock_in),
        .rst_b_in           (rst_b_in),
        .amp_reset_b_in     (amp_reset_b),
        .mute_b_in          (mute_b),
        .gain_select_msb_in (gsel_msb),
        .gain_select_lsb_in (gsel_lsb),
        .stage_out          (stage),
        .mod_clk_out        (mod_clk),
        .gain_mult_out      (gain_mult),
        .early_unmute_out   (early),
        .state_out          (state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // compare tasks
    task automatic mism(input logic [31:0] g, input logic [31:0] e);
        n_errors++;
        $display("ERROR %0t got %0h exp %0h", $time, g, e);
    endtask

    task automatic chk_state(input amrg_state_e e);
        n_checks++;
        if (state !== e) mism(state, e);
    endtask

    task automatic chk_stage(input logic m, input logic d, input logic [2:0] l);
        amrg_stage_s e;
        e = '{m, d, ~d, l};
        n_checks++;
        if (stage !== e) mism(stage, e);
    endtask

    task automatic chk_val(input logic [3:0] g, input logic [3:0] e);
        n_checks++;
        if (g !== e) mism(g, e);
    endtask

    task automatic chk_cnt(input int g, input int lo, input int hi);
        n_checks++;
        if (g < lo || g > hi) mism(g, lo);
    endtask

    // bounded wait for a state, counting cycles
    task automatic wait_st(input amrg_state_e s, output int n);
        n = 0;
        while (state !== s && n < 4000) begin
            @(negedge clock_in);
            n++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_quiet();
        repeat (10) @(negedge clock_in);
        chk_state(ST_RESET);
        chk_stage(1'h0, 1'h0, 3'h0);
        chk_val({3'h0, mod_clk}, 4'h0);
        $display("test reset_quiet done");
    endtask

    task automatic t_startup();
        int  n;
        logic m;
        logic sw;
        i_amrg_host.set_reset(1'h1);
        wait_st(ST_INIT, n);
        chk_cnt(n, 1, 5);
        chk_stage(1'h1, 1'h0, 3'h0);
        m = mod_clk;
        @(negedge clock_in);
        chk_val({3'h0, mod_clk}, {3'h0, ~m});
        wait_st(ST_MUTED, n);
        chk_cnt(n, INIT - 2, INIT + 2);
        chk_stage(1'h1, 1'h0, 3'h0);
        sw = 1'h0;
        repeat (100) begin
            @(negedge clock_in);
            if (stage.drive_en !== 1'h0) sw = 1'h1;
        end
        chk_val({3'h0, sw}, 4'h0);
        $display("test startup done");
    endtask

    task automatic t_early_unmute();
        int n;
        i_amrg_host.set_mute(1'h1);
        wait_st(ST_RUN, n);
        chk_cnt(n, UNM, UNM + 6);
        chk_stage(1'h1, 1'h1, 3'h7);
        chk_val({3'h0, early}, 4'h1);
        $display("test early_unmute done");
    endtask

    task automatic t_mute();
        int n;
        int k;
        i_amrg_host.set_mute(1'h0);
        wait_st(ST_MUTING, n);
        wait_st(ST_MUTED, k);
        chk_cnt(n + k, MUT - 3, MUT + 3);
        chk_stage(1'h1, 1'h0, 3'h0);
        $display("test mute done");
    endtask

    task automatic t_soft_unmute();
        int n;
        i_amrg_host.unmute_settled();
        wait_st(ST_SOFT, n);
        chk_cnt(n, UNM, UNM + 6);
        chk_stage(1'h1, 1'h1, 3'h0);
        chk_val({3'h0, early}, 4'h0);
        wait_st(ST_RUN, n);
        chk_cnt(n, RAMP - 2, RAMP + 2);
        chk_stage(1'h1, 1'h1, 3'h7);
        $display("test soft_unmute done");
    endtask

    task automatic t_gain();
        for (int g = 3; g >= 0; g--) begin
            i_amrg_host.set_gain(g[1:0]);
            repeat (5) @(negedge clock_in);
            chk_val(gain_mult, 4'h1 << g);
        end
        chk_state(ST_RUN);
        $display("test gain done");
    endtask

    // mute cut during the unmute wait and during the soft ramp
    task automatic t_mute_cut();
        int n;
        i_amrg_host.set_mute(1'h0);
        wait_st(ST_MUTED, n);
        i_amrg_host.set_mute(1'h1);
        wait_st(ST_UNWAIT, n);
        i_amrg_host.set_mute(1'h0);
        wait_st(ST_MUTED, n);
        chk_cnt(n, 1, 5);
        chk_stage(1'h1, 1'h0, 3'h0);
        i_amrg_host.set_mute(1'h1);
        wait_st(ST_SOFT, n);
        i_amrg_host.set_mute(1'h0);
        wait_st(ST_MUTING, n);
        chk_stage(1'h1, 1'h1, 3'h0);
        wait_st(ST_MUTED, n);
        chk_cnt(n, MUT - 3, MUT + 3);
        $display("test mute_cut done");
    endtask

    task automatic t_abort();
        int n;
        i_amrg_host.set_mute(1'h0);
        wait_st(ST_MUTED, n);
        i_amrg_host.unmute_settled();
        wait_st(ST_SOFT, n);
        i_amrg_host.set_reset(1'h0);
        wait_st(ST_RESET, n);
        chk_cnt(n, 1, 5);
        chk_stage(1'h0, 1'h0, 3'h0);
        chk_val({3'h0, mod_clk}, 4'h0);
        $display("test abort done");
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clock_in);
        @(negedge clock_in);
        rst_b_in = 1'h1;
        t_reset_quiet();
        t_startup();
        t_early_unmute();
        t_mute();
        t_soft_unmute();
        t_gain();
        t_mute_cut();
        t_abort();
        stop_test();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        stop_test();
    end
endmodule
